// File: pkg/ucs_map.svh
`ifndef UCS_MAP_SVH
`define UCS_MAP_SVH

// clock and program cycle timing, history taps, record depth and counts
`define UCS_CLK_KHZ        40000
`define UCS_PROG_CYCLE_US  5000
`define UCS_HIST_DEPTH     40
`define UCS_PRE_TRIG_TAP   3
`define UCS_PRE_FAULT_TAP  39
`define UCS_REC_DEPTH      12
`define UCS_REC_LAST       4'hB
`define UCS_N_CNT          5
`define UCS_N_EV           6
`define UCS_REMAIN_MAX     19'h57E40

// hysteresis and scaling
`define UCS_RESET_PCT      32'h00000061
`define UCS_PCT            32'h00000064
`define UCS_UNB_SCALE      32'h0000012C

// flag / event positions
`define UCS_F_ALSTART      0
`define UCS_F_ALARM        1
`define UCS_F_START        2
`define UCS_F_TRIP         3
`define UCS_F_BLOCK        4
`define UCS_F_HARM         5

// fault record kinds
`define UCS_K_START        2'h0
`define UCS_K_TRIP         2'h1
`define UCS_K_BLOCK        2'h2

// register offsets
`define UCS_A_CTRL         8'h00
`define UCS_A_HARM_LIM     8'h04
`define UCS_A_AL_SET       8'h08
`define UCS_A_TR_SET       8'h0C
`define UCS_A_AL_DLY       8'h10
`define UCS_A_TR_DLY       8'h14
`define UCS_A_STATUS       8'h18
`define UCS_A_INT_STAT     8'h1C
`define UCS_A_INT_MASK     8'h20
`define UCS_A_CNT_CLR      8'h24
`define UCS_A_CNT0         8'h28
`define UCS_A_CNT1         8'h2C
`define UCS_A_CNT2         8'h30
`define UCS_A_CNT3         8'h34
`define UCS_A_CNT4         8'h38
`define UCS_A_REC_SEL      8'h40
`define UCS_A_REC_INFO     8'h44
`define UCS_A_REC_STAMP    8'h48
`define UCS_A_REC_CUR      8'h4C
`define UCS_A_REC_PRF      8'h50
`define UCS_A_REC_RATIO    8'h54
`define UCS_A_REC_REMAIN   8'h58
`define UCS_A_TIMESTAMP    8'h5C

// reset values
`define UCS_RST_HARM_LIM   16'h07D0
`define UCS_RST_SET        16'h0078
`define UCS_RST_DLY        19'h00008
`define UCS_RST_STORE      6'h3F

`endif

// File: pkg/ucs_pkg.sv
package ucs_pkg;

  // one fault record
  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0]  kind;
    logic [15:0] pre_i;
    logic [15:0] flt_i;
    logic [15:0] prf_i;
    logic [15:0] r_al;
    logic [15:0] r_tr;
    logic [18:0] remain;
    logic [2:0]  group;
  } ucs_rec_t;

  // measurement inputs of the stage
  typedef struct packed {
    logic [15:0] i_l1;
    logic [15:0] i_l2;
    logic [15:0] i_l3;
    logic [15:0] h2_ratio;
    logic [2:0]  group;
  } ucs_meas_t;

  // timestamped event to the event buffer
  typedef struct packed {
    logic        valid;
    logic [2:0]  code;
    logic        on;
    logic [31:0] stamp;
  } ucs_event_t;

  // whole state of the stage
  typedef struct packed {
    logic [17:0]                tick_cnt;
    logic [31:0]                stamp;
    logic                       blk_smp;
    logic                       pu_al;
    logic                       pu_tr;
    logic [18:0]                al_cnt;
    logic [18:0]                tr_cnt;
    logic [5:0]                 flags;
    logic [5:0]                 pend_on;
    logic [5:0]                 pend_off;
    logic [31:0]                ev_stamp;
    ucs_event_t                 ev;
    logic [39:0][15:0]          hist;
    logic [11:0]                rec_used;
    ucs_rec_t [11:0]            recs;
    logic [3:0]                 rec_head;
    logic [4:0][15:0]           cnt;
    logic                       inrush_en;
    logic [5:0]                 store_on;
    logic [5:0]                 store_off;
    logic [15:0]                harm_lim;
    logic [15:0]                al_set;
    logic [15:0]                tr_set;
    logic [18:0]                al_dly;
    logic [18:0]                tr_dly;
    logic [5:0]                 int_stat;
    logic [5:0]                 int_mask;
    logic [3:0]                 rec_sel;
    logic [31:0]                rdata;
    logic                       irq;
  } ucs_state_t;

endpackage

// File: design/ucs_stage.sv
// Notes on behaviour
// - block input sampled once at each program cycle start, used all cycle
// - block comes from its own dedicated input fed by the blocking matrix
// - pick-up with block inactive raises start and runs operate delay
// - pick-up with block active raises blocked, no timing or tripping
// - block arriving during start clears start and resets timing as on drop-out
// - second-harmonic inrush block option, on or off, off by default
// - inrush block when harmonic ratio reaches limit, 0.01 % steps, default 20.00 %
// - on and off events for alarm-start, alarm, start, trip, block, harmonic-block
// - per event choice of storing on, off or both transitions
// - each stored event carries the time stamp of its status change
// - resettable counters of alarm-start, alarm, start, trip and blocked
// - ring of twelve fault records written on start, trip or blocked onset
// - record holds stamp, event, current 20 ms before, at, and 200 ms before
// - record holds alarm and trip ratios, remaining trip time, setting group
// - stage outputs usable for direct output control and user logic
// - unbalance is max minus min phase current over mean, against two thresholds
// - pick-up releases below 97 % of the threshold
`timescale 1ns/100ps
`include "ucs_map.svh"

module ucs_stage
  import ucs_pkg::*;
#(
  parameter int PROG_CLKS = `UCS_PROG_CYCLE_US * `UCS_CLK_KHZ / 1000
) (
  input  wire logic        clk,          // 40 MHz clock
  input  wire logic        reset_n,      // synchronous reset, active low
  input  wire logic [7:0]  addr,         // register byte address
  input  wire logic [31:0] wdata,        // write data
  input  wire logic        wr,           // write strobe
  input  wire logic        rd,           // read strobe
  output logic      [31:0] rdata,        // read data, cycle after rd
  input  wire logic        block_in,     // block from blocking matrix
  input  wire ucs_meas_t   meas,         // phase currents, 2nd harmonic, group
  output logic      [5:0]  stage_out,    // alarm-start..harm-block levels
  output ucs_event_t       event_out,    // timestamped event pulse
  output logic             irq           // level interrupt
);

  ucs_state_t s_r;
  ucs_state_t s_nxt;

  logic        tick;
  logic [15:0] imax;
  logic [15:0] imin;
  logic [17:0] isum;
  logic [31:0] unb_w;
  logic [15:0] unb;
  logic        harm;
  logic        blk;
  logic        pu_al_n;
  logic        pu_tr_n;
  logic [5:0]  new_flags;
  logic [5:0]  chg;
  logic [5:0]  on_ev;
  logic [5:0]  off_ev;
  logic [5:0]  int_clr;
  logic [4:0]  cnt_clr;
  logic [18:0] remain;
  logic [2:0]  idx;
  ucs_rec_t    rec;
  ucs_rec_t    sel;

  // lowest set bit of an event vector
  function automatic logic [2:0] f_first(input logic [5:0] v);
    f_first = 3'h0;
    for (int i = `UCS_N_EV - 1; i >= 0; i--) begin
      if (v[i]) begin
        f_first = 3'(i);
      end
    end
  endfunction

  // measured unbalance over a setting, in hundredths
  function automatic logic [15:0] f_ratio(input logic [15:0] m, input logic [15:0] set);
    logic [31:0] q;
    q = 32'h0;
    if (set != 16'h0) begin
      q = ({16'h0, m} * `UCS_PCT) / {16'h0, set};
    end
    f_ratio = (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
  endfunction

  // unbalance from the three phase currents
  always_comb begin
    imax = meas.i_l1;
    imin = meas.i_l1;
    if (meas.i_l2 > imax) imax = meas.i_l2;
    if (meas.i_l3 > imax) imax = meas.i_l3;
    if (meas.i_l2 < imin) imin = meas.i_l2;
    if (meas.i_l3 < imin) imin = meas.i_l3;
    isum  = {2'h0, meas.i_l1} + {2'h0, meas.i_l2} + {2'h0, meas.i_l3};
    unb_w = 32'h0;
    if (isum != 18'h0) begin
      unb_w = ({16'h0, imax - imin} * `UCS_UNB_SCALE) / {14'h0, isum};
    end
    unb = (unb_w > 32'h0000FFFF) ? 16'hFFFF : unb_w[15:0];
  end

  // next state of the whole stage
  always_comb begin
    s_nxt   = s_r;
    int_clr = 6'h0;
    cnt_clr = 5'h0;
    sel     = s_r.recs[s_r.rec_sel];

    // register writes
    if (wr) begin
      case (addr)
        `UCS_A_CTRL: begin
          s_nxt.inrush_en = wdata[0];
          s_nxt.store_on  = wdata[13:8];
          s_nxt.store_off = wdata[21:16];
        end
        `UCS_A_HARM_LIM: s_nxt.harm_lim = wdata[15:0];
        `UCS_A_AL_SET:   s_nxt.al_set   = wdata[15:0];
        `UCS_A_TR_SET:   s_nxt.tr_set   = wdata[15:0];
        `UCS_A_AL_DLY:   s_nxt.al_dly   = wdata[18:0];
        `UCS_A_TR_DLY:   s_nxt.tr_dly   = wdata[18:0];
        `UCS_A_INT_STAT: int_clr        = wdata[5:0];
        `UCS_A_INT_MASK: s_nxt.int_mask = wdata[5:0];
        `UCS_A_CNT_CLR:  cnt_clr        = wdata[4:0];
        `UCS_A_REC_SEL: begin
          s_nxt.rec_sel = (wdata[3:0] > `UCS_REC_LAST) ? `UCS_REC_LAST : wdata[3:0];
        end
        default: ;
      endcase
    end
    for (int i = 0; i < `UCS_N_CNT; i++) begin
      if (cnt_clr[i]) s_nxt.cnt[i] = 16'h0;
    end

    // register reads, data in the next cycle only
    s_nxt.rdata = 32'h0;
    if (rd) begin
      case (addr)
        `UCS_A_CTRL:      s_nxt.rdata = {10'h0, s_r.store_off, 2'h0, s_r.store_on,
                                         7'h0, s_r.inrush_en};
        `UCS_A_HARM_LIM:  s_nxt.rdata = {16'h0, s_r.harm_lim};
        `UCS_A_AL_SET:    s_nxt.rdata = {16'h0, s_r.al_set};
        `UCS_A_TR_SET:    s_nxt.rdata = {16'h0, s_r.tr_set};
        `UCS_A_AL_DLY:    s_nxt.rdata = {13'h0, s_r.al_dly};
        `UCS_A_TR_DLY:    s_nxt.rdata = {13'h0, s_r.tr_dly};
        `UCS_A_STATUS:    s_nxt.rdata = {25'h0, s_r.blk_smp, s_r.flags};
        `UCS_A_INT_STAT:  s_nxt.rdata = {26'h0, s_r.int_stat};
        `UCS_A_INT_MASK:  s_nxt.rdata = {26'h0, s_r.int_mask};
        `UCS_A_CNT0:      s_nxt.rdata = {16'h0, s_r.cnt[0]};
        `UCS_A_CNT1:      s_nxt.rdata = {16'h0, s_r.cnt[1]};
        `UCS_A_CNT2:      s_nxt.rdata = {16'h0, s_r.cnt[2]};
        `UCS_A_CNT3:      s_nxt.rdata = {16'h0, s_r.cnt[3]};
        `UCS_A_CNT4:      s_nxt.rdata = {16'h0, s_r.cnt[4]};
        `UCS_A_REC_SEL:   s_nxt.rdata = {28'h0, s_r.rec_sel};
        `UCS_A_REC_INFO:  s_nxt.rdata = {11'h0, s_r.rec_used[s_r.rec_sel], 1'b0, sel.group,
                                         2'h0, sel.kind, 8'h0, s_r.rec_head};
        `UCS_A_REC_STAMP: s_nxt.rdata = sel.stamp;
        `UCS_A_REC_CUR:   s_nxt.rdata = {sel.pre_i, sel.flt_i};
        `UCS_A_REC_PRF:   s_nxt.rdata = {16'h0, sel.prf_i};
        `UCS_A_REC_RATIO: s_nxt.rdata = {sel.r_tr, sel.r_al};
        `UCS_A_REC_REMAIN: s_nxt.rdata = {13'h0, sel.remain};
        `UCS_A_TIMESTAMP: s_nxt.rdata = s_r.stamp;
        default:          s_nxt.rdata = 32'h0;
      endcase
    end

    // drain one pending event per clock, on transitions first
    s_nxt.ev.valid = 1'b0;
    idx = 3'h0;
    if (|s_r.pend_on) begin
      idx = f_first(s_r.pend_on);
      s_nxt.pend_on[idx] = 1'b0;
      s_nxt.ev.valid     = 1'b1;
      s_nxt.ev.code      = idx;
      s_nxt.ev.on        = 1'b1;
      s_nxt.ev.stamp     = s_r.ev_stamp;
    end else if (|s_r.pend_off) begin
      idx = f_first(s_r.pend_off);
      s_nxt.pend_off[idx] = 1'b0;
      s_nxt.ev.valid      = 1'b1;
      s_nxt.ev.code       = idx;
      s_nxt.ev.on         = 1'b0;
      s_nxt.ev.stamp      = s_r.ev_stamp;
    end

    // program cycle divider
    tick = (s_r.tick_cnt == 18'(PROG_CLKS - 1));
    s_nxt.tick_cnt = tick ? 18'h0 : s_r.tick_cnt + 18'h1;

    // pick-up with fixed release hysteresis
    pu_al_n = s_r.pu_al
            ? ({16'h0, unb} * `UCS_PCT >= {16'h0, s_r.al_set} * `UCS_RESET_PCT)
            : (unb >= s_r.al_set);
    pu_tr_n = s_r.pu_tr
            ? ({16'h0, unb} * `UCS_PCT >= {16'h0, s_r.tr_set} * `UCS_RESET_PCT)
            : (unb >= s_r.tr_set);

    // blocking decisions on the sampled block level
    harm = s_r.inrush_en && (meas.h2_ratio >= s_r.harm_lim);
    blk  = block_in || harm;
    new_flags = s_r.flags;
    new_flags[`UCS_F_ALSTART] = pu_al_n && !blk;
    new_flags[`UCS_F_START]   = pu_tr_n && !blk;
    new_flags[`UCS_F_BLOCK]   = (pu_al_n || pu_tr_n) && blk;
    new_flags[`UCS_F_HARM]    = harm;

    // definite-time timers, stepped once per program cycle, cleared on release or block
    if (tick) begin
      s_nxt.al_cnt = 19'h0;
      s_nxt.tr_cnt = 19'h0;
      if (new_flags[`UCS_F_ALSTART] && s_r.al_cnt != 19'h7FFFF) begin
        s_nxt.al_cnt = s_r.al_cnt + 19'h1;
      end else if (new_flags[`UCS_F_ALSTART]) begin
        s_nxt.al_cnt = s_r.al_cnt;
      end
      if (new_flags[`UCS_F_START] && s_r.tr_cnt != 19'h7FFFF) begin
        s_nxt.tr_cnt = s_r.tr_cnt + 19'h1;
      end else if (new_flags[`UCS_F_START]) begin
        s_nxt.tr_cnt = s_r.tr_cnt;
      end
    end
    new_flags[`UCS_F_ALARM] = new_flags[`UCS_F_ALSTART] && (s_nxt.al_cnt >= s_r.al_dly);
    new_flags[`UCS_F_TRIP]  = new_flags[`UCS_F_START] && (s_nxt.tr_cnt >= s_r.tr_dly);
    remain = 19'h0;
    if (new_flags[`UCS_F_START] && s_r.tr_dly > s_nxt.tr_cnt) begin
      remain = s_r.tr_dly - s_nxt.tr_cnt;
    end
    if (remain > `UCS_REMAIN_MAX) remain = `UCS_REMAIN_MAX;

    chg    = tick ? (new_flags ^ s_r.flags) : 6'h0;
    on_ev  = chg & new_flags;
    off_ev = chg & ~new_flags;

    // fault record content for this program cycle
    rec.stamp  = s_r.stamp;
    rec.kind   = on_ev[`UCS_F_TRIP]  ? `UCS_K_TRIP
               : on_ev[`UCS_F_START] ? `UCS_K_START : `UCS_K_BLOCK;
    rec.pre_i  = s_r.hist[`UCS_PRE_TRIG_TAP];
    rec.flt_i  = imax;
    rec.prf_i  = s_r.hist[`UCS_PRE_FAULT_TAP];
    rec.r_al   = f_ratio(unb, s_r.al_set);
    rec.r_tr   = f_ratio(unb, s_r.tr_set);
    rec.remain = remain;
    rec.group  = meas.group;

    if (tick) begin
      s_nxt.blk_smp  = block_in;
      s_nxt.pu_al    = pu_al_n;
      s_nxt.pu_tr    = pu_tr_n;
      s_nxt.flags    = new_flags;
      s_nxt.stamp    = s_r.stamp + 32'h1;
      s_nxt.hist     = {s_r.hist[`UCS_HIST_DEPTH-2:0], imax};
      s_nxt.pend_on  = s_nxt.pend_on | (on_ev & s_r.store_on);
      s_nxt.pend_off = s_nxt.pend_off | (off_ev & s_r.store_off);
      if (|chg) s_nxt.ev_stamp = s_r.stamp;
      for (int i = 0; i < `UCS_N_CNT; i++) begin
        if (on_ev[i]) s_nxt.cnt[i] = s_nxt.cnt[i] + 16'h1;
      end
      if (on_ev[`UCS_F_START] || on_ev[`UCS_F_TRIP] || on_ev[`UCS_F_BLOCK]) begin
        s_nxt.recs[s_r.rec_head]     = rec;
        s_nxt.rec_used[s_r.rec_head] = 1'b1;
        s_nxt.rec_head = (s_r.rec_head == `UCS_REC_LAST) ? 4'h0 : s_r.rec_head + 4'h1;
      end
    end

    // sticky status, set wins over clear
    s_nxt.int_stat = (s_r.int_stat & ~int_clr) | chg;
    s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r           <= '0;
      s_r.store_on  <= `UCS_RST_STORE;
      s_r.store_off <= `UCS_RST_STORE;
      s_r.harm_lim  <= `UCS_RST_HARM_LIM;
      s_r.al_set    <= `UCS_RST_SET;
      s_r.tr_set    <= `UCS_RST_SET;
      s_r.al_dly    <= `UCS_RST_DLY;
      s_r.tr_dly    <= `UCS_RST_DLY;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign rdata     = s_r.rdata;
  assign stage_out = s_r.flags;
  assign event_out = s_r.ev;
  assign irq       = s_r.irq;

endmodule

// File: verification/ucs_checker.sv
`timescale 1ns/100ps
module ucs_checker
  import ucs_pkg::*;
#(
  parameter int PROG_CLKS = 200000
) (
  input wire logic        clk,       // clock
  input wire logic        reset_n,   // reset, active low
  input wire logic [7:0]  addr,      // bus address
  input wire logic [31:0] wdata,     // write data
  input wire logic        wr,        // write strobe
  input wire logic        rd,        // read strobe
  input wire logic [31:0] rdata,     // read data
  input wire logic        block_in,  // block level
  input wire ucs_meas_t   meas,      // measurements
  input wire logic [5:0]  stage_out, // stage levels
  input wire ucs_event_t  event_out, // event pulse
  input wire logic        irq        // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // read answer only in the cycle after a read
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read answer");
  AST_RD_UNMAPPED: assert property ($past(rd) && $past(addr) == 8'hFC |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  // blocked stage neither starts nor times
  AST_BLK_QUIET: assert property (stage_out[4] |-> stage_out[3:0] == 4'h0)
    else $error("start or timing while blocked");
  AST_TRIP_START: assert property (stage_out[3] |-> stage_out[2])
    else $error("trip without start");
  AST_ALARM_ALST: assert property (stage_out[1] |-> stage_out[0])
    else $error("alarm without alarm start");
  // outputs hold for eight clocks after each change
  AST_TICK_HOLD: assert property ($changed(stage_out) |=> $stable(stage_out)[*8])
    else $error("stage outputs changed between ticks");
  // events follow the levels, one stamp per burst, on before off
  AST_EV_LEVEL: assert property (event_out.valid |->
      event_out.code <= 3'h5 && stage_out[event_out.code] == event_out.on)
    else $error("event disagrees with stage level");
  AST_EV_STAMP: assert property (event_out.valid && $past(event_out.valid) |->
      event_out.stamp == $past(event_out.stamp))
    else $error("stamp changed within a burst");
  AST_EV_ORDER: assert property (event_out.valid && !event_out.on ##1 event_out.valid
      |-> !event_out.on)
    else $error("on event after off event");

  // main scenarios
  COV_TRIP: cover property ($rose(stage_out[3]));
  COV_BLOCK: cover property ($rose(stage_out[4]));
  COV_OFF_EV: cover property (event_out.valid && !event_out.on);
endmodule

bind ucs_stage ucs_checker #(.PROG_CLKS(PROG_CLKS)) u_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .block_in(block_in),
  .meas(meas), .stage_out(stage_out), .event_out(event_out), .irq(irq));

// File: verification/ucs_partner.sv
`timescale 1ns/100ps
module ucs_partner
  import ucs_pkg::*;
(
  input  wire logic clk,      // stage clock
  output logic      block_in, // block from the matrix
  output ucs_meas_t meas      // currents, harmonic, group
);
  // new levels launched just after an edge, held until changed
  task automatic put(input logic [15:0] a, b, c, h, input logic blk);
    @(posedge clk);
    meas <= '{a, b, c, h, 3'h5};
    block_in <= blk;
  endtask

  // balanced load, no block
  initial begin
    block_in = 1'b0;
    meas = '{16'h64, 16'h64, 16'h64, 16'h0, 3'h5};
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "ucs_map.svh"
module tb_top
  import ucs_pkg::*;
;
  localparam int P = 64;
  logic        clk, reset_n, wr, rd, irq, block_in;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [5:0]  stage_out;
  ucs_meas_t   meas;
  ucs_event_t  event_out;
  logic [3:0]  ev_q[$];
  logic [31:0] st_q[$];
  int          failures, checks_done, ph, cyc_n;

  ucs_stage #(.PROG_CLKS(P)) DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .block_in(block_in), .meas(meas),
    .stage_out(stage_out), .event_out(event_out), .irq(irq));
  ucs_partner PM (.clk(clk), .block_in(block_in), .meas(meas));

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // tick phase, timeout and event log
  always @(posedge clk) begin
    ph <= (!reset_n || ph == P - 1) ? 0 : ph + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 12000) begin
      failures++;
      give_verdict;
    end
    if (event_out.valid) begin
      ev_q.push_back({event_out.code, event_out.on});
      st_q.push_back(event_out.stamp);
    end
  end

  // wait n program ticks, land mid-cycle
  task automatic nxt(input int n);
    repeat (n) begin
      @(posedge clk);
      while (ph != 10) @(posedge clk);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // read one word and compare it
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(n, e, rdata);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // test sequence
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rc("ctrl", `UCS_A_CTRL, 32'h003F3F00);
    rc("harm_lim", `UCS_A_HARM_LIM, 32'h7D0);
    rc("al_set", `UCS_A_AL_SET, 32'h78);
    rc("tr_dly", `UCS_A_TR_DLY, 32'h8);
    rc("unmapped", 8'hFC, 32'h0);
    $display("test reset done");
    wr32(`UCS_A_AL_DLY, 32'h2);
    wr32(`UCS_A_TR_DLY, 32'h3);
    nxt(42);
    PM.put(16'hA0, 16'h64, 16'h28, 16'h0, 1'b0);
    ev_q.delete();
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h05);
    rc("int_stat", `UCS_A_INT_STAT, 32'h05);
    chk("irq", 32'h0, {31'h0, irq});
    wr32(`UCS_A_INT_MASK, 32'h4);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr32(`UCS_A_INT_STAT, 32'h4);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("ev0", 32'h1, {28'h0, ev_q[0]});
    chk("ev1", 32'h5, {28'h0, ev_q[1]});
    chk("ev_stamp", 32'h2A, st_q[0]);
    rc("stamp", `UCS_A_TIMESTAMP, 32'h2B);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h07);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h0F);
    chk("stage_out", 32'h0F, {26'h0, stage_out});
    for (int i = 0; i < 4; i++) rc("cnt", 8'(8'h28 + 4 * i), 32'h1);
    wr32(`UCS_A_REC_SEL, 32'h0);
    rc("rec_info", `UCS_A_REC_INFO, 32'h00150002);
    rc("rec_cur", `UCS_A_REC_CUR, 32'h006400A0);
    rc("rec_prf", `UCS_A_REC_PRF, 32'h64);
    rc("rec_ratio", `UCS_A_REC_RATIO, 32'h00640064);
    rc("rec_remain", `UCS_A_REC_REMAIN, 32'h2);
    wr32(`UCS_A_REC_SEL, 32'h1);
    rc("rec_info", `UCS_A_REC_INFO, 32'h00151002);
    rc("rec_remain", `UCS_A_REC_REMAIN, 32'h0);
    $display("test pickup done");
    PM.put(16'h9E, 16'h65, 16'h29, 16'h0, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h0F);
    PM.put(16'h9E, 16'h64, 16'h2A, 16'h0, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h00);
    $display("test release done");
    PM.put(16'hA0, 16'h64, 16'h28, 16'h0, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h05);
    PM.put(16'hA0, 16'h64, 16'h28, 16'h0, 1'b1);
    PM.put(16'hA0, 16'h64, 16'h28, 16'h0, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h07);
    wr32(`UCS_A_CTRL, 32'h003F2F00);
    wr32(`UCS_A_CNT_CLR, 32'h1F);
    rc("cnt1", `UCS_A_CNT1, 32'h0);
    ev_q.delete();
    PM.put(16'hA0, 16'h64, 16'h28, 16'h0, 1'b1);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h50);
    chk("stage_out", 32'h10, {26'h0, stage_out});
    chk("ev_n", 32'h3, ev_q.size());
    chk("ev_first", 32'h0, {28'h0, ev_q[0]});
    rc("cnt4", `UCS_A_CNT4, 32'h1);
    wr32(`UCS_A_REC_SEL, 32'h3);
    rc("rec_info", `UCS_A_REC_INFO, 32'h00152004);
    wr32(`UCS_A_REC_SEL, 32'hF);
    rc("rec_sel", `UCS_A_REC_SEL, 32'hB);
    nxt(4);
    rc("status", `UCS_A_STATUS, 32'h50);
    $display("test block done");
    PM.put(16'h64, 16'h64, 16'h64, 16'h7D0, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h00);
    wr32(`UCS_A_CTRL, 32'h003F3F01);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h20);
    PM.put(16'h64, 16'h64, 16'h64, 16'h7CF, 1'b0);
    nxt(1);
    rc("status", `UCS_A_STATUS, 32'h00);
    $display("test inrush done");
    give_verdict;
  end
endmodule
